// *** hw/exec_map.svh ***
// constants for the subtract, nibble exchange and direction load decoder
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH
`define OPC_SUB_WORK_FROM_FILE 6'h02
`define OPC_NIBBLE_EXCHANGE 6'h0e
`define OPC_DIR_LOAD 9'h000
`define DIR_SEL_FIRST 3'h5
`define DIR_SEL_LAST 4'h9
`define DIR_COUNT 5
`define W_RESET 8'h00
`define DIR_RESET 8'hff
`define OPC_HI 11
`define OPC_LO 6
`define DIR_OPC_LO 3
`define DEST_BIT 5
`define ADDR_HI 4
`define SEL_HI 2
`define DIR_SEL_NONE 3'h0
`define DIR_SEL_TOP 3'h7
`endif

// *** hw/exec_pkg.sv ***
// types shared by the instruction decoder
package exec_pkg;
   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_SUB = 2'h1,
      OP_SWAP = 2'h3,
      OP_DIR = 2'h2
   } op_e;
endpackage

// *** hw/subtract_swap_dirload_exec.sv ***
// decode and execute of subtract, nibble exchange and direction load
// Operation
// - subtract computes file minus working and writes it to working when d is 0, else to the file register.
// - nibble exchange swaps the two nibbles of the file register and leaves all flags alone.
// - nibble exchange writes to working when d is clear, else back to the file register.
// - direction load copies working into the direction register picked by operands 5 to 7, working unchanged.
`timescale 1ns/10ps
`default_nettype none
`include "exec_map.svh"
module subtract_swap_dirload_exec #(
   parameter int WIDTH = 8
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic INSTR_VALID,
   input wire logic [11:0] INSTR,
   input wire logic [WIDTH-1:0] FILE_RDATA,
   output logic [4:0] FILE_ADDR,
   output logic FILE_WE,
   output logic [WIDTH-1:0] FILE_WDATA,
   output logic [WIDTH-1:0] WORK,
   output logic CARRY,
   output logic DIGIT_CARRY_FLAG,
   output logic ZERO,
   output logic [`DIR_COUNT*WIDTH-1:0] PORT_DIRECTION,
   output logic ILLEGAL
);
   typedef struct packed {
      logic [WIDTH-1:0] work;
      logic carry;
      logic digit_carry;
      logic zero;
      logic file_we;
      logic [4:0] file_addr;
      logic [WIDTH-1:0] file_wdata;
      logic illegal;
      logic [`DIR_COUNT-1:0][WIDTH-1:0] dir;
   } state_s;

   state_s st_r;
   state_s st_nxt;
   exec_pkg::op_e op;
   logic dest;
   logic [WIDTH:0] diff;
   logic [4:0] low_diff;
   logic [WIDTH-1:0] result;
   logic [3:0] dir_sel;
   logic wr_req;

   always_comb begin
      dest = INSTR[`DEST_BIT];
      dir_sel = {1'b0, INSTR[`SEL_HI:0]};
      if (!INSTR_VALID) begin
         op = exec_pkg::OP_NONE;
      end else if (INSTR[`OPC_HI:`OPC_LO] == `OPC_SUB_WORK_FROM_FILE) begin
         op = exec_pkg::OP_SUB;
      end else if (INSTR[`OPC_HI:`OPC_LO] == `OPC_NIBBLE_EXCHANGE) begin
         op = exec_pkg::OP_SWAP;
      end else if (INSTR[`OPC_HI:`DIR_OPC_LO] == `OPC_DIR_LOAD &&
            INSTR[`SEL_HI:0] != `DIR_SEL_NONE) begin
         op = exec_pkg::OP_DIR;
      end else begin
         op = exec_pkg::OP_NONE;
      end
      // file write request, watched by the checks below
      wr_req = dest && (op == exec_pkg::OP_SUB || op == exec_pkg::OP_SWAP);
      // two's complement: borrow-free when the carry out is set
      diff = {1'b0, FILE_RDATA} + {1'b0, ~st_r.work} + {{WIDTH{1'b0}}, 1'b1};
      low_diff = {1'b0, FILE_RDATA[3:0]} + {1'b0, ~st_r.work[3:0]} + 5'h01;
      result = FILE_RDATA;
      st_nxt = st_r;
      st_nxt.file_we = 1'b0;
      st_nxt.illegal = 1'b0;
      st_nxt.file_addr = INSTR[`ADDR_HI:0];
      case (op)
         exec_pkg::OP_SUB: begin
            result = diff[WIDTH-1:0];
            st_nxt.carry = diff[WIDTH];
            st_nxt.digit_carry = low_diff[4];
            st_nxt.zero = (diff[WIDTH-1:0] == '0);
         end
         exec_pkg::OP_SWAP: begin
            result = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
         end
         default: begin
         end
      endcase
      case (op)
         exec_pkg::OP_SUB, exec_pkg::OP_SWAP: begin
            // one write per cycle, so nothing waits on the file port
            if (dest) begin
               st_nxt.file_we = 1'b1;
               st_nxt.file_wdata = result;
            end else begin
               st_nxt.work = result;
            end
         end
         exec_pkg::OP_DIR: begin
            // unselectable codes are flagged rather than silently dropped
            if (dir_sel >= {1'b0, `DIR_SEL_FIRST} && dir_sel <= `DIR_SEL_LAST) begin
               st_nxt.dir[dir_sel - {1'b0, `DIR_SEL_FIRST}] = st_r.work;
            end else begin
               st_nxt.illegal = 1'b1;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         st_r <= '0;
         st_r.work <= `W_RESET;
         for (int i = 0; i < `DIR_COUNT; i++) begin
            st_r.dir[i] <= `DIR_RESET;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   assign WORK = st_r.work;
   assign CARRY = st_r.carry;
   assign DIGIT_CARRY_FLAG = st_r.digit_carry;
   assign ZERO = st_r.zero;
   assign FILE_WE = st_r.file_we;
   assign FILE_ADDR = st_r.file_addr;
   assign FILE_WDATA = st_r.file_wdata;
   assign ILLEGAL = st_r.illegal;
   assign PORT_DIRECTION = st_r.dir;
   // upper two direction registers sit past the 3-bit operand and
   // only ever hold their reset value

   sequence s_sub_to_work;
      op == exec_pkg::OP_SUB && !dest;
   endsequence
   sequence s_sub_to_file;
      op == exec_pkg::OP_SUB && dest;
   endsequence
   sequence s_swap_taken;
      op == exec_pkg::OP_SWAP;
   endsequence
   sequence s_dir_taken;
      op == exec_pkg::OP_DIR;
   endsequence
   sequence s_refused;
      INSTR_VALID && op == exec_pkg::OP_NONE;
   endsequence
   sequence s_flags_held;
      $stable(CARRY) && $stable(ZERO) && $stable(DIGIT_CARRY_FLAG);
   endsequence

   a_sub_dest: assert property (@(posedge CLK) disable iff (RESET)
      op == exec_pkg::OP_SUB && dest |=> FILE_WE &&
      FILE_WDATA == $past(FILE_RDATA) - $past(WORK))
      else $error("subtract to file wrong");
   a_sub_work: assert property (@(posedge CLK) disable iff (RESET)
      op == exec_pkg::OP_SUB && !dest |=> !FILE_WE &&
      WORK == $past(FILE_RDATA) - $past(WORK))
      else $error("subtract to working wrong");
   a_swap_flags: assert property (@(posedge CLK) disable iff (RESET)
      op == exec_pkg::OP_SWAP |=> $stable(CARRY) && $stable(ZERO) &&
      $stable(DIGIT_CARRY_FLAG))
      else $error("swap changed a flag");
   a_swap_dest: assert property (@(posedge CLK) disable iff (RESET)
      op == exec_pkg::OP_SWAP && !dest |=>
      WORK == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
      else $error("swap to working wrong");
   a_swap_file: assert property (@(posedge CLK) disable iff (RESET)
      op == exec_pkg::OP_SWAP && dest |=> FILE_WE && $stable(WORK) &&
      FILE_WDATA == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])})
      else $error("swap to file wrong");
   a_dir_load: assert property (@(posedge CLK) disable iff (RESET)
      op == exec_pkg::OP_DIR && INSTR[2:0] == 3'h6 |=>
      PORT_DIRECTION[15:8] == $past(WORK) && $stable(WORK) && !FILE_WE)
      else $error("direction load wrong");
   a_carry_borrow: assert property (@(posedge CLK) disable iff (RESET)
      op == exec_pkg::OP_SUB |=> CARRY == ($past(FILE_RDATA) >= $past(WORK))
      && ZERO == ($past(FILE_RDATA) == $past(WORK)))
      else $error("carry or zero wrong");
   a_digit_carry: assert property (@(posedge CLK) disable iff (RESET)
      op == exec_pkg::OP_SUB |=>
      DIGIT_CARRY_FLAG == ($past(FILE_RDATA[3:0]) >= $past(WORK[3:0])))
      else $error("digit carry wrong");

   a_sub_chain: assert property (@(posedge CLK) disable iff (RESET)
      s_sub_to_work ##1 s_sub_to_file |=>
      FILE_WDATA == $past(FILE_RDATA) -
      ($past(FILE_RDATA, 2) - $past(WORK, 2)))
      else $error("back to back subtract wrong");
   a_swap_keep: assert property (@(posedge CLK) disable iff (RESET)
      s_swap_taken ##0 !dest |=> s_flags_held ##0 !FILE_WE)
      else $error("swap to working wrote the file");
   a_we_source: assert property (@(posedge CLK) disable iff (RESET)
      FILE_WE |-> $past(wr_req))
      else $error("file write without a request");
   a_we_target: assert property (@(posedge CLK) disable iff (RESET)
      wr_req |=> FILE_WE && FILE_ADDR == $past(INSTR[`ADDR_HI:0]))
      else $error("file write address wrong");
   a_refused_quiet: assert property (@(posedge CLK) disable iff (RESET)
      s_refused |=> (!FILE_WE && !ILLEGAL && $stable(WORK) &&
      $stable(PORT_DIRECTION)) ##0 s_flags_held)
      else $error("refused word changed state");
   a_dir_flags: assert property (@(posedge CLK) disable iff (RESET)
      s_dir_taken |=> s_flags_held)
      else $error("direction load changed a flag");
   a_dir_illegal: assert property (@(posedge CLK) disable iff (RESET)
      s_dir_taken ##0 (dir_sel < {1'b0, `DIR_SEL_FIRST}) |=>
      ILLEGAL && $stable(PORT_DIRECTION) && $stable(WORK))
      else $error("bad select not flagged");
   a_dir_legal: assert property (@(posedge CLK) disable iff (RESET)
      s_dir_taken ##0 (dir_sel >= {1'b0, `DIR_SEL_FIRST}) |=>
      !ILLEGAL && !FILE_WE && $stable(WORK))
      else $error("legal select flagged");
   a_dir_first: assert property (@(posedge CLK) disable iff (RESET)
      s_dir_taken ##0 (INSTR[`SEL_HI:0] == `DIR_SEL_FIRST) |=>
      PORT_DIRECTION[WIDTH-1:0] == $past(WORK))
      else $error("first direction register wrong");
   a_dir_top: assert property (@(posedge CLK) disable iff (RESET)
      s_dir_taken ##0 (INSTR[`SEL_HI:0] == `DIR_SEL_TOP) |=>
      PORT_DIRECTION[3*WIDTH-1:2*WIDTH] == $past(WORK))
      else $error("top direction register wrong");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the subtract, swap and direction load decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic reset, valid, fwe, carry, digit_carry, zero, illegal;
   logic [11:0] instr;
   logic [7:0] rdata, fwdata, work;
   logic [4:0] faddr;
   logic [39:0] pdir;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   subtract_swap_dirload_exec u_dut (.CLK(clk), .RESET(reset),
      .INSTR_VALID(valid), .INSTR(instr), .FILE_RDATA(rdata),
      .FILE_ADDR(faddr), .FILE_WE(fwe), .FILE_WDATA(fwdata), .WORK(work),
      .CARRY(carry), .DIGIT_CARRY_FLAG(digit_carry), .ZERO(zero),
      .PORT_DIRECTION(pdir), .ILLEGAL(illegal));
   always #5 clk = ~clk;
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one idle cycle between instructions keeps valid from repeating
   task automatic run(input logic [11:0] i, input logic [7:0] d);
      @(posedge clk);
      instr <= i;
      rdata <= d;
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      rdata <= ~d;
      #1;
   endtask
   task automatic reset_test;
      #1;
      chk(work, 8'h00);
      chk(pdir, {5{8'hff}});
      chk({carry, digit_carry, zero, fwe, illegal}, 5'h00);
   endtask
   task automatic sub_test;
      run({6'h02, 1'b0, 5'h01}, 8'h35);
      chk(work, 8'h35);
      chk({carry, digit_carry, zero, fwe}, 4'b1100);
      run({6'h02, 1'b1, 5'h03}, 8'h34);
      chk({fwe, faddr, fwdata}, {1'b1, 5'h03, 8'hff});
      chk({work, carry, digit_carry, zero}, {8'h35, 3'b000});
      run({6'h02, 1'b0, 5'h04}, 8'h35);
      chk({work, carry, digit_carry, zero, fwe}, {8'h00, 4'b1110});
   endtask
   task automatic swap_test;
      run({6'h0e, 1'b0, 5'h02}, 8'ha5);
      chk(work, 8'h5a);
      chk({carry, digit_carry, zero, fwe}, 4'b1110);
      run({6'h0e, 1'b1, 5'h1f}, 8'hc3);
      chk({fwe, faddr, fwdata, work}, {6'h3f, 8'h3c, 8'h5a});
   endtask
   task automatic dir_test;
      run({9'h000, 3'h5}, 8'h00);
      run({9'h000, 3'h7}, 8'h00);
      chk(pdir, {16'hffff, 8'h5a, 8'hff, 8'h5a});
      chk({work, fwe}, {8'h5a, 1'b0});
      chk({carry, digit_carry, zero}, 3'h7);
      // fresh working value so the middle register proves its own select
      run({6'h0e, 1'b0, 5'h07}, 8'h12);
      chk(work, 8'h21);
      run({9'h000, 3'h6}, 8'h00);
      chk(pdir, {16'hffff, 8'h5a, 8'h21, 8'h5a});
      chk({work, illegal}, {8'h21, 1'b0});
      // select below the legal range must leave every direction register alone
      run({9'h000, 3'h2}, 8'h00);
      chk(illegal, 1'b1);
      chk(pdir, {16'hffff, 8'h5a, 8'h21, 8'h5a});
   endtask
   task automatic refused_test;
      // undecoded word and the empty direction select change nothing
      run(12'h800, 8'h00);
      chk({work, fwe, illegal}, {8'h21, 2'h0});
      chk({carry, digit_carry, zero}, 3'h7);
      run(12'h000, 8'h00);
      chk({work, fwe, illegal}, {8'h21, 2'h0});
      chk(pdir, {16'hffff, 8'h5a, 8'h21, 8'h5a});
   endtask
   task automatic burst_test;
      // second subtract must see the working value the first just wrote
      @(posedge clk);
      instr <= {6'h02, 1'b0, 5'h05};
      rdata <= 8'h80;
      valid <= 1'b1;
      @(posedge clk);
      instr <= {6'h02, 1'b1, 5'h06};
      rdata <= 8'h5f;
      #1;
      chk({work, carry, digit_carry, zero, fwe}, {8'h5f, 4'h8});
      @(posedge clk);
      valid <= 1'b0;
      #1;
      chk({fwe, faddr, fwdata, work}, {6'h26, 8'h00, 8'h5f});
      chk({carry, digit_carry, zero}, 3'h7);
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_count++;
         end_sim;
      end
   end
   initial begin
      reset = 1'b1;
      valid = 1'b0;
      instr = 12'h000;
      rdata = 8'h00;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      reset_test;
      sub_test;
      swap_test;
      dir_test;
      refused_test;
      burst_test;
      end_sim;
   end
endmodule
`default_nettype wire
